/* scse_bench.sv */
// Purpose: register-level bench for the socket change block
// Assumes: two functions, socket pins driven by the bench
// Notes:   pin changes wait six cycles to clear the two-flop sync
`default_nettype none

module scse_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // stimulus and tasks
  // ==========================================================================
  logic        clk = 1'b0, rst = 1'b1, bus_rst_n = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [1:0]  sel = '0, cb = '0, crst = '0;
  logic [5:0]  addr = '0;
  logic [3:0]  be = '0;
  logic [31:0] wdata = '0;
  logic [7:0]  ln = '0;
  wire logic [31:0] rdata;
  wire logic        rvalid;
  wire logic [1:0]  irq;
  int miscompares = 0, n_tests = 0;
  logic [5:0]  offs [10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h3c};
  logic [8:0]  gate [7] = '{{4'h8, 4'h0, 1'b0}, {4'h8, 4'h8, 1'b1}, {4'h2, 4'h2, 1'b0}, {4'h2, 4'h4, 1'b0},
                            {4'h2, 4'h6, 1'b1}, {4'h1, 4'h1, 1'b1}, {4'h1, 4'he, 1'b0}};

  always #50 clk = ~clk;

  scse_top #(.NUM_FUNC(2)) scse_top_i (
    .i_ref_clk(clk), .i_rst(rst), .i_bus_reset_n(bus_rst_n), .i_reg_sel(sel), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_power_cycle({ln[7], ln[3]}), .i_detect_one({ln[5], ln[1]}),
    .i_detect_two({ln[6], ln[2]}), .i_card_status_line({ln[4], ln[0]}), .i_card_reset(crst),
    .i_cardbus_card(cb), .o_status_change_interrupt(irq));

  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // strobes last one cycle; the next access waits for a fresh edge
  task automatic acc(input int f, input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 2'h1 << f;
    wr <= w;
    rd <= !w;
    addr <= a;
    be <= 4'hf;
    wdata <= d;
    @(posedge clk);
    sel <= '0;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : acc

  task automatic wr_reg(input int f, input logic [5:0] a, input logic [31:0] d);
    acc(f, 1'b1, a, d);
  endtask : wr_reg

  task automatic rd_reg(input int f, input logic [5:0] a, input logic [31:0] e);
    acc(f, 1'b0, a, 32'h0);
    chk({rvalid, rdata}, {1'b1, e});
  endtask : rd_reg

  task automatic chk_irq(input logic [1:0] e);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  task automatic set_ln(input logic [7:0] v, input logic c, input logic r);
    @(posedge clk);
    ln <= v;
    cb <= {1'b0, c};
    crst <= {1'b0, r};
    repeat (6) @(posedge clk);
  endtask : set_ln

  task automatic brst;
    @(posedge clk);
    bus_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    bus_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : brst

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rd_reg(0, offs[i], offs[i] == 6'h08 ? 32'h3000_0000 : 32'h0);
    wr_reg(0, 6'h04, 32'hffff_ffff);
    rd_reg(0, 6'h04, 32'h0000_000f);
    rd_reg(1, 6'h04, 32'h0);
    wr_reg(0, 6'h04, 32'h0);
    wr_reg(0, 6'h0c, 32'h0000_000f);
    rd_reg(0, 6'h00, 32'h0000_000f);
    wr_reg(0, 6'h00, 32'h0000_0005);
    rd_reg(0, 6'h00, 32'h0000_000a);
    wr_reg(0, 6'h00, 32'hffff_fffa);
    rd_reg(0, 6'h00, 32'h0);
    for (int k = 1; k < 4; k++) begin
      set_ln(8'h1 << k, 1'b0, 1'b0);
      rd_reg(0, 6'h00, 32'h1 << k);
      set_ln(8'h0, 1'b0, 1'b0);
      rd_reg(0, 6'h00, 32'h1 << k);
      wr_reg(0, 6'h00, 32'hf);
    end
    for (int t = 0; t < 2; t++) begin
      set_ln(8'h01, t[0], 1'b0);
      rd_reg(0, 6'h00, 32'h1);
      wr_reg(0, 6'h00, 32'h1);
      set_ln(8'h00, t[0], 1'b0);
      rd_reg(0, 6'h00, t ? 32'h0 : 32'h1);
      wr_reg(0, 6'h00, 32'h1);
    end
    set_ln(8'h20, 1'b0, 1'b0);
    rd_reg(1, 6'h00, 32'h2);
    rd_reg(0, 6'h00, 32'h0);
    wr_reg(1, 6'h04, 32'h6);
    chk_irq(2'h2);
    wr_reg(1, 6'h04, 32'h0);
    foreach (gate[i]) begin
      wr_reg(0, 6'h04, {28'h0, gate[i][4:1]});
      wr_reg(0, 6'h0c, {28'h0, gate[i][8:5]});
      rd_reg(0, 6'h00, {28'h0, gate[i][8:5]});
      chk_irq({1'b0, gate[i][0]});
      wr_reg(0, 6'h00, 32'hf);
      rd_reg(0, 6'h00, 32'h0);
      chk_irq(2'h0);
    end
    // clear is taken on the very edge at which the synced line sets the flag
    @(posedge clk);
    ln <= 8'h02;
    @(posedge clk);
    wr_reg(0, 6'h00, 32'hf);
    rd_reg(0, 6'h00, 32'h2);
    wr_reg(0, 6'h00, 32'hf);
    set_ln(8'h02, 1'b0, 1'b1);
    set_ln(8'h02, 1'b0, 1'b0);
    rd_reg(0, 6'h00, 32'h2);
    set_ln(8'h00, 1'b0, 1'b0);
    wr_reg(0, 6'h04, 32'h6);
    brst;
    rd_reg(0, 6'h00, 32'h0);
    rd_reg(0, 6'h04, 32'h0);
    wr_reg(0, 6'h20, 32'h1);
    wr_reg(0, 6'h0c, 32'hf);
    wr_reg(0, 6'h04, 32'hf);
    brst;
    rd_reg(0, 6'h00, 32'hf);
    rd_reg(0, 6'h04, 32'hf);
    chk_irq(2'h1);
    rd_reg(0, 6'h20, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(0, 6'h20, 32'h0);
    rd_reg(0, 6'h00, 32'h0);
    wr_reg(0, 6'h0c, 32'hc000_3c00);
    rd_reg(0, 6'h08, 32'hf000_3c00);
    rd_reg(0, 6'h0c, 32'h0);
    complete_run;
  end

endmodule : scse_bench

`default_nettype wire

/* scse_checker.sv */
// Purpose: port-level checks for the socket change block
// Assumes: one clock, synchronous active-high global reset
// Notes:   flag state is internal, so checks lean on read path and irq
`default_nettype none

module scse_checker #(
  parameter int NUM_FUNC = 2
) (
  input wire logic                        i_ref_clk,
  input wire logic                        i_rst,
  input wire logic                        i_bus_reset_n,
  input wire logic [NUM_FUNC-1:0]         i_reg_sel,
  input wire logic                        i_reg_wr,
  input wire logic                        i_reg_rd,
  input wire logic [scse_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [scse_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic                        o_reg_rvalid,
  input wire logic [NUM_FUNC-1:0]         o_status_change_interrupt
);
  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic       rd_hit = i_reg_rd && (|i_reg_sel);
  wire logic [3:0] word   = i_reg_addr[5:2];

  a_read_answer: assert property (rd_hit |=> o_reg_rvalid) else $error("read not answered");
  a_no_spurious: assert property (!rd_hit |=> !o_reg_rvalid) else $error("stray read answer");
  a_idle_zero: assert property (!o_reg_rvalid |-> o_reg_rdata == '0) else $error("data without answer");
  a_upper_zero: assert property (rd_hit && word[3:1] == 3'h0 |=> o_reg_rdata[31:4] == '0)
    else $error("upper flag or enable bits set");
  a_rsvd_zero: assert property (rd_hit && (word inside {4'h3, 4'h5, 4'h6, 4'h7} || word > 4'h8)
    |=> o_reg_rdata == '0) else $error("reserved word not zero");
  a_caps_shown: assert property (rd_hit && word == 4'h2 |=> o_reg_rdata[29:28] == 2'h3)
    else $error("state word lost capability bits");
  // sync reset must quiet outputs, so this one runs through reset
  a_rst_quiet: assert property (disable iff (1'b0) i_rst |=> !o_reg_rvalid && o_status_change_interrupt == '0)
    else $error("outputs active after reset");
  // irq drops only via a write or a synced bus reset
  a_irq_drop_cause: assert property (|($past(o_status_change_interrupt) & ~o_status_change_interrupt)
    |-> $past(i_reg_wr) || !$past(i_bus_reset_n, 2) || !$past(i_bus_reset_n, 3) || !$past(i_bus_reset_n, 4))
    else $error("interrupt dropped without cause");

  c_irq_rise: cover property ($rose(|o_status_change_interrupt));
  c_flag_read: cover property (rd_hit && word == 4'h0 ##1 o_reg_rdata[3:0] != 4'h0);
  c_bus_reset: cover property ($fell(i_bus_reset_n));

endmodule : scse_checker

bind scse_top scse_checker #(.NUM_FUNC(NUM_FUNC)) scse_checker_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus_reset_n(i_bus_reset_n), .i_reg_sel(i_reg_sel),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_status_change_interrupt(o_status_change_interrupt));

`default_nettype wire

/* scse_event_core.sv */
// Purpose: sticky change flags, enables and interrupt for one function
// Assumes: set and clear vectors are one-cycle qualified by the caller
// Notes:   context reset is built by the caller from the reset policy
`default_nettype none

module scse_event_core (
  input  wire logic        i_ref_clk,
  input  wire logic        i_ctx_rst,
  input  wire logic [3:0]  i_set,
  input  wire logic [3:0]  i_clear,
  input  wire logic        i_enables_we,
  input  wire logic [3:0]  i_enables_wdata,
  output logic      [3:0]  o_flags,
  output logic      [3:0]  o_enables,
  output logic             o_irq
);

  // ==========================================================================
  // flags and enables
  // ==========================================================================
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic [3:0] enables_reg;
  logic [3:0] enables_next;
  logic [3:0] gate_next;
  logic       irq_reg;
  logic       detect_on;

  assign flags_next   = (flags_reg & ~i_clear) | i_set;
  assign enables_next = i_enables_we ? i_enables_wdata : enables_reg;
  assign detect_on    = (enables_next[scse_pkg::EV_DETECT_TWO:scse_pkg::EV_DETECT_ONE] == scse_pkg::DETECT_EN_ON);
  assign gate_next    = {enables_next[scse_pkg::EV_POWER_CYC], detect_on, detect_on,
                         enables_next[scse_pkg::EV_CARD_STAT]};

  always_ff @(posedge i_ref_clk) begin
    if (i_ctx_rst) begin
      flags_reg   <= scse_pkg::FLAGS_RESET;
      enables_reg <= scse_pkg::ENABLES_RESET;
      irq_reg     <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      enables_reg <= enables_next;
      irq_reg     <= |(flags_next & gate_next);
    end
  end

  assign o_flags   = flags_reg;
  assign o_enables = enables_reg;
  assign o_irq     = irq_reg;

endmodule : scse_event_core

`default_nettype wire

/* scse_pkg.sv */
// Purpose: shared constants for the socket status-change event block
// Assumes: byte offsets inside one function's socket register window
// Notes:   every function carries an identical copy of this map
`default_nettype none

package scse_pkg;

  // ==========================================================================
  // register window
  // ==========================================================================
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 32;
  localparam logic [5:0]  OFF_FLAGS     = 6'h00;
  localparam logic [5:0]  OFF_ENABLES   = 6'h04;
  localparam logic [5:0]  OFF_STATE     = 6'h08;
  localparam logic [5:0]  OFF_FORCE     = 6'h0c;
  localparam logic [5:0]  OFF_CONTROL   = 6'h10;
  localparam logic [5:0]  OFF_RSVD_LO   = 6'h14;
  localparam logic [5:0]  OFF_RSVD_HI   = 6'h1c;
  localparam logic [5:0]  OFF_PWR_MGMT  = 6'h20;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // ==========================================================================
  // event flags and enables, low nibble of their words
  // ==========================================================================
  localparam int          EV_W          = 4;
  localparam int          EV_CARD_STAT  = 0;
  localparam int          EV_DETECT_ONE = 1;
  localparam int          EV_DETECT_TWO = 2;
  localparam int          EV_POWER_CYC  = 3;
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  localparam logic [3:0]  ENABLES_RESET = 4'h0;
  localparam logic [1:0]  DETECT_EN_ON  = 2'h3;

  // ==========================================================================
  // current state word
  // ==========================================================================
  localparam int          ST_CARDBUS    = 5;
  localparam logic [31:0] SOCKET_CAPS   = 32'h3000_0000;
  localparam logic [31:0] FORCE_OVR_MSK = 32'hc000_3c00;
  localparam logic [31:0] OVR_RESET     = 32'h0000_0000;

  // ==========================================================================
  // control and power management
  // ==========================================================================
  localparam int          CONTROL_W     = 8;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam int          PM_PME_EN     = 0;
  localparam int          PM_CTX_LO     = 8;
  localparam int          PM_CTX_W      = 8;
  localparam logic [7:0]  PM_CTX_RESET  = 8'h00;

endpackage : scse_pkg

`default_nettype wire

/* scse_sync.sv */
// Purpose: two-flop synchroniser for socket pins and the bus reset
// Assumes: bits are independent levels; no word coherence
// Notes:   first stage feeds only the second stage
`default_nettype none

module scse_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  input  wire logic [W-1:0]   i_async,
  output logic      [W-1:0]   o_sync
);

  // ==========================================================================
  // two stages
  // ==========================================================================
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : scse_sync

`default_nettype wire

/* scse_top.sv */
// Purpose: socket register window with change events, one copy per function
// Assumes: i_rst is the global reset; bus reset arrives as a pin
// Notes:   reads answer one cycle later through a registered data word
`default_nettype none

module scse_top #(
  parameter int NUM_FUNC = 2
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_bus_reset_n,
  input  wire logic [NUM_FUNC-1:0]               i_reg_sel,
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [scse_pkg::ADDR_W-1:0]       i_reg_addr,
  input  wire logic [3:0]                        i_reg_be,
  input  wire logic [scse_pkg::DATA_W-1:0]       i_reg_wdata,
  output logic      [scse_pkg::DATA_W-1:0]       o_reg_rdata,
  output logic                                   o_reg_rvalid,
  input  wire logic [NUM_FUNC-1:0]               i_power_cycle,
  input  wire logic [NUM_FUNC-1:0]               i_detect_one,
  input  wire logic [NUM_FUNC-1:0]               i_detect_two,
  input  wire logic [NUM_FUNC-1:0]               i_card_status_line,
  input  wire logic [NUM_FUNC-1:0]               i_card_reset,
  input  wire logic [NUM_FUNC-1:0]               i_cardbus_card,
  output logic      [NUM_FUNC-1:0]               o_status_change_interrupt
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  localparam int WORD_LSB = 2;

  // word compare ignores the two byte bits of the address
  function automatic logic word_hit(input logic [scse_pkg::ADDR_W-1:0] addr,
                                    input logic [scse_pkg::ADDR_W-1:0] off);
    word_hit = (addr[scse_pkg::ADDR_W-1:WORD_LSB] == off[scse_pkg::ADDR_W-1:WORD_LSB]);
  endfunction : word_hit

  // ==========================================================================
  // pin synchronisation
  // ==========================================================================
  // all socket lines share one synchroniser word; bus reset rides in the top bit
  localparam int PIN_GROUPS = 6;
  localparam int GRP_PWR    = 0;
  localparam int GRP_CD1    = 1;
  localparam int GRP_CD2    = 2;
  localparam int GRP_CST    = 3;
  localparam int GRP_CRST   = 4;
  localparam int GRP_CBUS   = 5;

  localparam int SYNC_W = NUM_FUNC * PIN_GROUPS + 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

  logic [SYNC_W-1:0]   pins_async;
  logic [SYNC_W-1:0]   pins_sync;
  logic [NUM_FUNC-1:0] pwr_s;
  logic [NUM_FUNC-1:0] cd1_s;
  logic [NUM_FUNC-1:0] cd2_s;
  logic [NUM_FUNC-1:0] cst_s;
  logic [NUM_FUNC-1:0] crst_s;
  logic [NUM_FUNC-1:0] cbus_s;
  logic                bus_rst_s;

  assign pins_async = {i_bus_reset_n, i_cardbus_card, i_card_reset, i_card_status_line,
                       i_detect_two, i_detect_one, i_power_cycle};

  scse_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (pins_async),
    .o_sync    (pins_sync)
  );

  assign pwr_s     = pins_sync[NUM_FUNC*GRP_PWR  +: NUM_FUNC];
  assign cd1_s     = pins_sync[NUM_FUNC*GRP_CD1  +: NUM_FUNC];
  assign cd2_s     = pins_sync[NUM_FUNC*GRP_CD2  +: NUM_FUNC];
  assign cst_s     = pins_sync[NUM_FUNC*GRP_CST  +: NUM_FUNC];
  assign crst_s    = pins_sync[NUM_FUNC*GRP_CRST +: NUM_FUNC];
  assign cbus_s    = pins_sync[NUM_FUNC*GRP_CBUS +: NUM_FUNC];
  // bus reset is active low at the pin
  assign bus_rst_s = ~pins_sync[SYNC_W-1];

  // ==========================================================================
  // access decode, shared by all functions
  // ==========================================================================
  logic [31:0] wmask;
  logic        hit_flags;
  logic        hit_enables;
  logic        hit_state;
  logic        hit_force;
  logic        hit_control;
  logic        hit_pm;
  logic        any_sel;

  assign wmask       = i_reg_wdata & lane_mask(i_reg_be);
  assign any_sel     = |i_reg_sel;
  assign hit_flags   = word_hit(i_reg_addr, scse_pkg::OFF_FLAGS);
  assign hit_enables = word_hit(i_reg_addr, scse_pkg::OFF_ENABLES);
  assign hit_state   = word_hit(i_reg_addr, scse_pkg::OFF_STATE);
  assign hit_force   = word_hit(i_reg_addr, scse_pkg::OFF_FORCE);
  assign hit_control = word_hit(i_reg_addr, scse_pkg::OFF_CONTROL);
  assign hit_pm      = word_hit(i_reg_addr, scse_pkg::OFF_PWR_MGMT);

  // ==========================================================================
  // per-function register sets
  // ==========================================================================
  logic [NUM_FUNC-1:0][31:0] func_rdata;

  for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func

    logic        wr_here;
    logic        ctx_rst;
    logic [3:0]  set_vec;
    logic [3:0]  clr_vec;
    logic [3:0]  force_vec;
    logic [3:0]  flags;
    logic [3:0]  enables;
    logic        irq;
    logic        cst_rise;
    logic        cst_fall;
    logic        cst_change;
    logic        reset_end;
    logic        enables_we;
    logic [31:0] state_word;
    logic [31:0] rd_word;

    logic        prev_pwr_reg;
    logic        prev_cd1_reg;
    logic        prev_cd2_reg;
    logic        prev_cst_reg;
    logic        prev_crst_reg;
    logic [31:0] ovr_reg;
    logic [31:0] ovr_next;
    logic [scse_pkg::CONTROL_W-1:0] control_reg;
    logic [scse_pkg::CONTROL_W-1:0] control_next;
    logic        pme_en_reg;
    logic        pme_en_next;
    logic [scse_pkg::PM_CTX_W-1:0]  pm_ctx_reg;
    logic [scse_pkg::PM_CTX_W-1:0]  pm_ctx_next;

    assign wr_here = i_reg_sel[f] & i_reg_wr;

    // reset policy by PME
    // pme enable is not context, so a bus reset cannot undo the policy itself
    assign ctx_rst = i_rst | (bus_rst_s & ~pme_en_reg);

    // ------------------------------------------------------------------------
    // change detection on synchronised lines
    // ------------------------------------------------------------------------
    assign cst_rise   = cst_s[f] & ~prev_cst_reg;
    assign cst_fall   = ~cst_s[f] & prev_cst_reg;
    // edge choice by card type
    // card type passes the same sync, so it ages in step with the line
    assign cst_change = cbus_s[f] ? cst_rise : (cst_rise | cst_fall);
    assign reset_end  = prev_crst_reg & ~crst_s[f];

    assign force_vec = (wr_here & hit_force) ? wmask[scse_pkg::EV_W-1:0] : 4'h0;

    // flags say only that something changed
    assign set_vec[scse_pkg::EV_POWER_CYC]  = (pwr_s[f] ^ prev_pwr_reg)
                                            | force_vec[scse_pkg::EV_POWER_CYC];
    assign set_vec[scse_pkg::EV_DETECT_TWO] = (cd2_s[f] ^ prev_cd2_reg) | (reset_end & cd2_s[f])
                                            | force_vec[scse_pkg::EV_DETECT_TWO];
    assign set_vec[scse_pkg::EV_DETECT_ONE] = (cd1_s[f] ^ prev_cd1_reg) | (reset_end & cd1_s[f])
                                            | force_vec[scse_pkg::EV_DETECT_ONE];
    assign set_vec[scse_pkg::EV_CARD_STAT]  = cst_change | (reset_end & cst_s[f])
                                            | force_vec[scse_pkg::EV_CARD_STAT];

    assign clr_vec    = (wr_here & hit_flags) ? wmask[scse_pkg::EV_W-1:0] : 4'h0;
    assign enables_we = wr_here & hit_enables & i_reg_be[0];

    scse_event_core u_core (
      .i_ref_clk       (i_ref_clk),
      .i_ctx_rst       (ctx_rst),
      .i_set           (set_vec),
      .i_clear         (clr_vec),
      .i_enables_we    (enables_we),
      .i_enables_wdata (i_reg_wdata[scse_pkg::EV_W-1:0]),
      .o_flags         (flags),
      .o_enables       (enables),
      .o_irq           (irq)
    );

    assign o_status_change_interrupt[f] = irq;

    // ------------------------------------------------------------------------
    // forced state bits, control and power management
    // ------------------------------------------------------------------------
    // forced bits stay visible
    assign ovr_next     = (wr_here & hit_force) ? (ovr_reg | (wmask & scse_pkg::FORCE_OVR_MSK))
                        : ovr_reg;
    assign control_next = (wr_here & hit_control & i_reg_be[0])
                        ? i_reg_wdata[scse_pkg::CONTROL_W-1:0] : control_reg;
    assign pme_en_next  = (wr_here & hit_pm & i_reg_be[0])
                        ? i_reg_wdata[scse_pkg::PM_PME_EN] : pme_en_reg;
    assign pm_ctx_next  = (wr_here & hit_pm & i_reg_be[1])
                        ? i_reg_wdata[scse_pkg::PM_CTX_LO +: scse_pkg::PM_CTX_W] : pm_ctx_reg;

    // previous samples only track lines, so the global reset suffices
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        prev_pwr_reg  <= 1'b0;
        prev_cd1_reg  <= 1'b0;
        prev_cd2_reg  <= 1'b0;
        prev_cst_reg  <= 1'b0;
        prev_crst_reg <= 1'b0;
      end else begin
        prev_pwr_reg  <= pwr_s[f];
        prev_cd1_reg  <= cd1_s[f];
        prev_cd2_reg  <= cd2_s[f];
        prev_cst_reg  <= cst_s[f];
        prev_crst_reg <= crst_s[f];
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (ctx_rst) begin
        ovr_reg     <= scse_pkg::OVR_RESET;
        control_reg <= scse_pkg::CONTROL_RESET;
        pm_ctx_reg  <= scse_pkg::PM_CTX_RESET;
      end else begin
        ovr_reg     <= ovr_next;
        control_reg <= control_next;
        pm_ctx_reg  <= pm_ctx_next;
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        pme_en_reg <= 1'b0;
      end else begin
        pme_en_reg <= pme_en_next;
      end
    end

    // ------------------------------------------------------------------------
    // read data for this function
    // ------------------------------------------------------------------------
    always_comb begin
      state_word = scse_pkg::SOCKET_CAPS | ovr_reg;
      state_word[scse_pkg::EV_POWER_CYC]  = pwr_s[f];
      state_word[scse_pkg::EV_DETECT_TWO] = cd2_s[f];
      state_word[scse_pkg::EV_DETECT_ONE] = cd1_s[f];
      state_word[scse_pkg::EV_CARD_STAT]  = cst_s[f];
      state_word[scse_pkg::ST_CARDBUS]    = cbus_s[f];
    end

    // reserved gap and unmapped words fall through to zero
    always_comb begin
      rd_word = scse_pkg::READ_ZERO;
      if (hit_flags) begin
        rd_word[scse_pkg::EV_W-1:0] = flags;
      end else if (hit_enables) begin
        rd_word[scse_pkg::EV_W-1:0] = enables;
      end else if (hit_state) begin
        rd_word = state_word;
      end else if (hit_control) begin
        rd_word[scse_pkg::CONTROL_W-1:0] = control_reg;
      end else if (hit_pm) begin
        rd_word[scse_pkg::PM_PME_EN] = pme_en_reg;
        rd_word[scse_pkg::PM_CTX_LO +: scse_pkg::PM_CTX_W] = pm_ctx_reg;
      end
    end

    // unselected functions feed zero into the merge
    assign func_rdata[f] = i_reg_sel[f] ? rd_word : scse_pkg::READ_ZERO;

  end : g_func

  // ==========================================================================
  // read return
  // ==========================================================================
  logic [31:0] rd_merge;
  logic [31:0] rdata_reg;
  logic        rvalid_reg;

  // selects are one-hot; an overlap would merge words rather than hang
  always_comb begin
    rd_merge = scse_pkg::READ_ZERO;
    for (int k = 0; k < NUM_FUNC; k++) begin
      rd_merge = rd_merge | func_rdata[k];
    end
  end

  // a read without any select gets no answer and zero data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg  <= scse_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= (i_reg_rd & any_sel) ? rd_merge : scse_pkg::READ_ZERO;
      rvalid_reg <= i_reg_rd & any_sel;
    end
  end

  // idle zero lets an outer return path OR this word with others
  assign o_reg_rdata  = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

endmodule : scse_top

`default_nettype wire
